/* File: dtmc_pkg.sv */
// dtmc_pkg: register map, field positions and mode codes of the dual timer mode control
// assumes a 32-bit word-wide register port; offsets are byte addresses
package dtmc_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CLOCK_ENABLE = 8'h50;
  localparam logic [7:0] ADDR_PAIR_CONFIG  = 8'h54;

  // ---------------------------------------------------------------
  // field positions and masks
  // ---------------------------------------------------------------
  localparam int          BIT_CHAN1_GATE  = 7;
  localparam int          BIT_CHAN0_GATE  = 6;
  localparam int          BIT_HALT_RUN    = 5;
  localparam int          BIT_CHAN1_IDLE  = 7;
  localparam int          BIT_CHAN0_IDLE  = 6;
  localparam logic [31:0] MASK_ENABLE     = 32'h0000_00E0;
  localparam logic [31:0] MASK_CONFIG     = 32'h0000_00C7;
  localparam logic [31:0] RESET_VALUE     = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

  // ---------------------------------------------------------------
  // operation mode codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_TIMER_TIMER = 3'h0,
    MODE_TIMER_PULSE = 3'h1,
    MODE_PULSE_TIMER = 3'h2,
    MODE_PULSE_PULSE = 3'h3,
    MODE_SYNC_START  = 3'h4,
    MODE_BAD_5       = 3'h5,
    MODE_BAD_6       = 3'h6,
    MODE_INTERLOCK   = 3'h7
  } dtmc_mode_type;

  // per-channel control bundle handed to the counter datapath
  typedef struct packed {
    logic clock_on;
    logic count_run;
    logic pulse_mode;
  } dtmc_chan_ctl_type;

endpackage : dtmc_pkg

/* File: dtmc_top.sv */
// dtmc_top: enable/configuration registers and per-channel gating for two timer channels
// assumes single-cycle strobes from the register master and a downstream counter datapath
// Operation
// - enable bit 7 gates the clock into channel 1, one on and zero off.
// - enable bit 6 gates the clock into channel 0, one on and zero off.
// - with debug halt active the up counters freeze unless enable bit 5 is one.
// - in idle mode channel 1 runs only while configuration bit 7 is one.
// - in idle mode channel 0 runs only while configuration bit 6 is one.
// - mode codes 000 to 011 choose timer or pulse generator per channel.
// - mode 100 runs both channels as timers that start together.
// - mode 111 runs an interlocked pulse pair with adjustable phase.
// - in mode 111 both count clocks share the channel 0 frequency.
// - in mode 111 channel 1 clears on the channel 0 sixth comparator match.
`timescale 1ns/1ns

module dtmc_top (
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_reset,
  input  wire logic [7:0]                    i_addr,
  input  wire logic [31:0]                   i_wdata,
  input  wire logic                          i_write,
  input  wire logic                          i_read,
  input  wire logic                          i_debug_halt,
  input  wire logic                          i_idle_mode,
  input  wire logic                          i_chan0_run_req,
  input  wire logic                          i_chan1_run_req,
  input  wire logic                          i_chan0_count_clock,
  input  wire logic                          i_chan1_count_clock,
  input  wire logic                          i_chan1_period_match,
  input  wire logic                          i_chan0_sixth_comparator,
  output logic      [31:0]                   o_rdata,
  output dtmc_pkg::dtmc_chan_ctl_type        o_chan0_ctl,
  output dtmc_pkg::dtmc_chan_ctl_type        o_chan1_ctl,
  output logic                               o_chan1_count_clock,
  output logic                               o_chan1_clear,
  output logic                               o_sync_start,
  output logic                               o_interlock,
  output logic      [2:0]                    o_mode
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0]            enable_reg;
  logic [31:0]            config_reg;
  dtmc_pkg::dtmc_mode_type mode;
  logic                   chan0_pulse;
  logic                   chan1_pulse;
  logic                   run_both;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      enable_reg <= dtmc_pkg::RESET_VALUE;
    end else if (i_write && i_addr == dtmc_pkg::ADDR_CLOCK_ENABLE) begin
      enable_reg <= i_wdata & dtmc_pkg::MASK_ENABLE;
    end
  end

  // forbidden codes are stored as written; decode treats them as plain timers
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      config_reg <= dtmc_pkg::RESET_VALUE;
    end else if (i_write && i_addr == dtmc_pkg::ADDR_PAIR_CONFIG) begin
      config_reg <= i_wdata & dtmc_pkg::MASK_CONFIG;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= dtmc_pkg::READ_ZERO;
    end else if (i_read) begin
      case (i_addr)
        dtmc_pkg::ADDR_CLOCK_ENABLE: o_rdata <= enable_reg;
        dtmc_pkg::ADDR_PAIR_CONFIG:  o_rdata <= config_reg;
        default:                     o_rdata <= dtmc_pkg::READ_ZERO;
      endcase
    end else begin
      o_rdata <= dtmc_pkg::READ_ZERO;
    end
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  assign mode = dtmc_pkg::dtmc_mode_type'(config_reg[2:0]);

  always_comb begin
    chan0_pulse  = 1'b0;
    chan1_pulse  = 1'b0;
    o_sync_start = 1'b0;
    o_interlock  = 1'b0;
    case (mode)
      dtmc_pkg::MODE_TIMER_TIMER: chan0_pulse = 1'b0;
      dtmc_pkg::MODE_TIMER_PULSE: chan1_pulse = 1'b1;
      dtmc_pkg::MODE_PULSE_TIMER: chan0_pulse = 1'b1;
      dtmc_pkg::MODE_PULSE_PULSE: begin
        chan0_pulse = 1'b1;
        chan1_pulse = 1'b1;
      end
      dtmc_pkg::MODE_SYNC_START: o_sync_start = 1'b1;
      dtmc_pkg::MODE_INTERLOCK: begin
        chan0_pulse = 1'b1;
        chan1_pulse = 1'b1;
        o_interlock = 1'b1;
      end
      default: o_sync_start = 1'b0;
    endcase
  end

  assign o_mode = config_reg[2:0];

  // ---------------------------------------------------------------
  // gating: clock gate, debug halt and idle stop per channel
  // ---------------------------------------------------------------
  // sync start holds both counters until both run requests are present
  assign run_both = i_chan0_run_req & i_chan1_run_req;

  always_comb begin
    o_chan0_ctl.clock_on   = enable_reg[dtmc_pkg::BIT_CHAN0_GATE];
    o_chan1_ctl.clock_on   = enable_reg[dtmc_pkg::BIT_CHAN1_GATE];
    o_chan0_ctl.pulse_mode = chan0_pulse;
    o_chan1_ctl.pulse_mode = chan1_pulse;
    o_chan0_ctl.count_run  = enable_reg[dtmc_pkg::BIT_CHAN0_GATE]
                           & (o_sync_start ? run_both : i_chan0_run_req)
                           & (~i_debug_halt | enable_reg[dtmc_pkg::BIT_HALT_RUN])
                           & (~i_idle_mode | config_reg[dtmc_pkg::BIT_CHAN0_IDLE]);
    o_chan1_ctl.count_run  = enable_reg[dtmc_pkg::BIT_CHAN1_GATE]
                           & (o_sync_start ? run_both : i_chan1_run_req)
                           & (~i_debug_halt | enable_reg[dtmc_pkg::BIT_HALT_RUN])
                           & (~i_idle_mode | config_reg[dtmc_pkg::BIT_CHAN1_IDLE]);
  end

  // interlocked pair shares channel 0's prescaled clock so phases stay locked
  assign o_chan1_count_clock = o_interlock ? i_chan0_count_clock
                                           : i_chan1_count_clock;
  assign o_chan1_clear = o_interlock ? i_chan0_sixth_comparator
                                     : i_chan1_period_match;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  unused_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_read && i_addr == dtmc_pkg::ADDR_CLOCK_ENABLE) |=> (o_rdata[4:0] == 5'h00
      && o_rdata[31:8] == 24'h000000))
    else $error("enable register unused bits not zero");
  gate_one_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_write && i_addr == dtmc_pkg::ADDR_CLOCK_ENABLE && !i_wdata[7])
      |=> !o_chan1_ctl.clock_on && !o_chan1_ctl.count_run)
    else $error("channel 1 clock not stopped");
  gate_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_write && i_addr == dtmc_pkg::ADDR_CLOCK_ENABLE) |=> o_chan0_ctl.clock_on == $past(i_wdata[6]))
    else $error("channel 0 clock gate wrong");
  halt_freeze_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_debug_halt && !enable_reg[5]) |-> !o_chan0_ctl.count_run && !o_chan1_ctl.count_run)
    else $error("counter runs through debug halt");
  idle_one_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_idle_mode && !config_reg[7]) |-> !o_chan1_ctl.count_run)
    else $error("channel 1 runs in idle");
  idle_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_idle_mode && !config_reg[6]) |-> !o_chan0_ctl.count_run)
    else $error("channel 0 runs in idle");
  mode_pulse_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (config_reg[2] == 1'b0) |-> (o_chan0_ctl.pulse_mode == config_reg[1]
      && o_chan1_ctl.pulse_mode == config_reg[0]))
    else $error("per-channel mode decode wrong");
  sync_start_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_sync_start |-> o_chan0_ctl.count_run == o_chan1_ctl.count_run
      || enable_reg[7:6] != 2'h3 || i_idle_mode)
    else $error("sync start channels diverge");
  interlock_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (config_reg[2:0] == 3'h7) |-> o_interlock && o_chan0_ctl.pulse_mode && o_chan1_ctl.pulse_mode)
    else $error("interlock mode not decoded");
  shared_clock_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_interlock |-> o_chan1_count_clock == i_chan0_count_clock)
    else $error("interlock clocks differ");
  sixth_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_interlock |-> o_chan1_clear == i_chan0_sixth_comparator)
    else $error("channel 1 clear source wrong");

  // ---------------------------------------------------------------
  // checks: register port
  // ---------------------------------------------------------------
  // read data must stand exactly one cycle after the strobe, zero otherwise
  read_enable_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_read && i_addr == dtmc_pkg::ADDR_CLOCK_ENABLE)
      |=> o_rdata == $past(enable_reg))
    else $error("enable register read data wrong");
  read_config_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_read && i_addr == dtmc_pkg::ADDR_PAIR_CONFIG)
      |=> o_rdata == $past(config_reg))
    else $error("configuration register read data wrong");
  config_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_read && i_addr == dtmc_pkg::ADDR_PAIR_CONFIG)
      |=> (o_rdata[5:3] == 3'h0 && o_rdata[31:8] == 24'h000000))
    else $error("configuration register unused bits not zero");
  rdata_idle_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !i_read |=> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  unmapped_read_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_read && i_addr != dtmc_pkg::ADDR_CLOCK_ENABLE
      && i_addr != dtmc_pkg::ADDR_PAIR_CONFIG) |=> o_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  write_enable_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_write && i_addr == dtmc_pkg::ADDR_CLOCK_ENABLE)
      |=> enable_reg == ($past(i_wdata) & dtmc_pkg::MASK_ENABLE))
    else $error("enable register write did not land");
  write_config_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_write && i_addr == dtmc_pkg::ADDR_PAIR_CONFIG)
      |=> config_reg == ($past(i_wdata) & dtmc_pkg::MASK_CONFIG))
    else $error("configuration register write did not land");
  unmapped_write_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (!i_write || (i_addr != dtmc_pkg::ADDR_CLOCK_ENABLE
      && i_addr != dtmc_pkg::ADDR_PAIR_CONFIG))
      |=> ($stable(enable_reg) && $stable(config_reg)))
    else $error("registers changed without a mapped write");

  // ---------------------------------------------------------------
  // checks: gating
  // ---------------------------------------------------------------
  run_gate1_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_chan1_ctl.count_run |-> o_chan1_ctl.clock_on)
    else $error("channel 1 counts without its clock");
  run_gate0_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_chan0_ctl.count_run |-> o_chan0_ctl.clock_on)
    else $error("channel 0 counts without its clock");
  gate_on1_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_write && i_addr == dtmc_pkg::ADDR_CLOCK_ENABLE && i_wdata[7])
      |=> o_chan1_ctl.clock_on)
    else $error("channel 1 clock not supplied");
  // a halt only freezes counting; the clock itself keeps running
  halt_clock_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_debug_halt |-> (o_chan0_ctl.clock_on == enable_reg[6]
      && o_chan1_ctl.clock_on == enable_reg[7]))
    else $error("debug halt stopped a channel clock");
  halt_run_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_debug_halt && enable_reg[5] && enable_reg[6] && !i_idle_mode && !o_sync_start)
      |-> o_chan0_ctl.count_run == i_chan0_run_req)
    else $error("counter stopped although halt run is set");
  idle_run1_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_idle_mode && config_reg[7] && enable_reg[7] && !i_debug_halt && !o_sync_start)
      |-> o_chan1_ctl.count_run == i_chan1_run_req)
    else $error("channel 1 stopped in idle although allowed");
  idle_run0_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_idle_mode && config_reg[6] && enable_reg[6] && !i_debug_halt && !o_sync_start)
      |-> o_chan0_ctl.count_run == i_chan0_run_req)
    else $error("channel 0 stopped in idle although allowed");

  // ---------------------------------------------------------------
  // checks: mode decode
  // ---------------------------------------------------------------
  mode_out_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_mode == config_reg[2:0])
    else $error("mode output differs from stored field");
  timer_both_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (config_reg[2:0] == 3'h0) |-> (!o_chan0_ctl.pulse_mode && !o_chan1_ctl.pulse_mode))
    else $error("timer pair decoded as pulse");
  sync_only_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_sync_start |-> config_reg[2:0] == 3'h4)
    else $error("sync start outside its mode");
  sync_pulse_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_sync_start |-> (!o_chan0_ctl.pulse_mode && !o_chan1_ctl.pulse_mode))
    else $error("sync start channels not timers");
  // neither counter may start alone while the pair waits for a common start
  sync_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (o_sync_start && !(i_chan0_run_req && i_chan1_run_req))
      |-> (!o_chan0_ctl.count_run && !o_chan1_ctl.count_run))
    else $error("sync start counter began alone");
  interlock_only_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_interlock |-> config_reg[2:0] == 3'h7)
    else $error("interlock outside its mode");
  bad_code_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (config_reg[2:0] == 3'h5 || config_reg[2:0] == 3'h6)
      |-> (!o_sync_start && !o_interlock && !o_chan0_ctl.pulse_mode))
    else $error("forbidden code not decoded as timers");
  own_clock_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !o_interlock |-> o_chan1_count_clock == i_chan1_count_clock)
    else $error("channel 1 lost its own clock");
  own_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !o_interlock |-> o_chan1_clear == i_chan1_period_match)
    else $error("channel 1 lost its own period clear");

endmodule : dtmc_top

/* File: dtmc_top_tb.sv */
// dtmc_top_tb: random register and gating checks of the dual timer mode control
// assumes the design's register port answers reads exactly one cycle later
`timescale 1ns/1ns
module dtmc_top_tb;
  logic        i_clk_sys, i_reset, i_write, i_read;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, o_rdata, en, cf, r, rd;
  logic        dh, idl, r0, r1, c0, c1, pmt, six;
  logic        o_chan1_count_clock, o_chan1_clear, o_sync_start, o_interlock;
  logic [2:0]  o_mode, m;
  dtmc_pkg::dtmc_chan_ctl_type o_chan0_ctl, o_chan1_ctl;
  int          n_mismatch, checks_done;
  dtmc_top dtmc_top_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .i_debug_halt(dh),
    .i_idle_mode(idl), .i_chan0_run_req(r0), .i_chan1_run_req(r1),
    .i_chan0_count_clock(c0), .i_chan1_count_clock(c1), .i_chan1_period_match(pmt),
    .i_chan0_sixth_comparator(six), .o_rdata(o_rdata), .o_chan0_ctl(o_chan0_ctl),
    .o_chan1_ctl(o_chan1_ctl), .o_chan1_count_clock(o_chan1_count_clock),
    .o_chan1_clear(o_chan1_clear), .o_sync_start(o_sync_start), .o_interlock(o_interlock),
    .o_mode(o_mode));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // full-word accesses only, one-cycle strobes
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_addr <= a; i_wdata <= d; i_write <= 1'b1;
    @(posedge i_clk_sys);
    i_write <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    i_addr <= a; i_read <= 1'b1;
    @(posedge i_clk_sys);
    i_read <= 1'b0;
    #1 d = o_rdata;
  endtask : bus_rd
  function automatic logic [2:0] exp_ctl(input int ch);
    logic g, s, p;
    g = en[6+ch];
    s = (cf[2:0] == 3'h4) ? (r0 & r1) : 1'b1;
    p = (cf[2:0] == 3'h3) || (cf[2:0] == 3'h7) || (cf[2:0] == ((ch == 0) ? 3'h2 : 3'h1));
    return {g, g & (ch == 0 ? r0 : r1) & (en[5] | ~dh) & (~idl | cf[6+ch]) & s, p};
  endfunction : exp_ctl
  // ---------------------------------------------------------------
  // clock, watchdog, main sequence
  // ---------------------------------------------------------------
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    n_mismatch++;
    complete_run();
  end
  initial begin
    {i_reset, i_write, i_read, i_addr, i_wdata} = {1'b1, 42'h0};
    {dh, idl, r0, r1, c0, c1, pmt, six} = 8'h00;
    n_mismatch = 0;
    checks_done = 0;
    void'($urandom(78));
    repeat (20) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    for (int i = 0; i < 300; i++) begin
      en = $urandom;
      cf = $urandom;
      m = (i < 8) ? 3'(i) : cf[2:0];
      if (m == 3'h5 || m == 3'h6) m = 3'h7;
      cf[2:0] = m;
      bus_wr(dtmc_pkg::ADDR_CLOCK_ENABLE, en);
      bus_wr(dtmc_pkg::ADDR_PAIR_CONFIG, cf);
      r = $urandom;
      if (i < 8) r[5:0] = 6'h3F;
      {dh, idl, r0, r1, c0, c1, pmt, six} <= r[7:0];
      @(posedge i_clk_sys);
      #1;
      check("chan0 ctl", 32'(o_chan0_ctl), 32'(exp_ctl(0)));
      check("chan1 ctl", 32'(o_chan1_ctl), 32'(exp_ctl(1)));
      check("sync", 32'(o_sync_start), 32'(m == 3'h4));
      check("interlock", 32'(o_interlock), 32'(m == 3'h7));
      check("mode", 32'(o_mode), 32'(m));
      check("clk1", 32'(o_chan1_count_clock), 32'((m == 3'h7) ? c0 : c1));
      check("clear1", 32'(o_chan1_clear), 32'((m == 3'h7) ? six : pmt));
      check("idle rdata", o_rdata, 32'h0000_0000);
      bus_rd(dtmc_pkg::ADDR_CLOCK_ENABLE, rd);
      check("enable rd", rd, en & 32'h0000_00E0);
      bus_rd(dtmc_pkg::ADDR_PAIR_CONFIG, rd);
      check("config rd", rd, cf & 32'h0000_00C7);
      r = $urandom;
      if (r[7:0] == 8'h50 || r[7:0] == 8'h54) r[7:0] = 8'h58;
      bus_wr(r[7:0], 32'hFFFF_FFFF);
      bus_rd(r[7:0], rd);
      check("unmapped rd", rd, 32'h0000_0000);
    end
    // registers clear again on a reset in mid-run
    @(posedge i_clk_sys);
    i_reset <= 1'b1;
    @(posedge i_clk_sys);
    i_reset <= 1'b0;
    bus_rd(dtmc_pkg::ADDR_CLOCK_ENABLE, rd);
    check("enable rst", rd, 32'h0000_0000);
    bus_rd(dtmc_pkg::ADDR_PAIR_CONFIG, rd);
    check("config rst", rd, 32'h0000_0000);
    complete_run();
  end
endmodule : dtmc_top_tb
